/* File: pkg/sst_pkg.sv */
package sst_pkg;
    // register map, 16-bit words at their word offsets
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam logic [15:0] OFF_STRAP_ONE = 16'h0009;
    localparam logic [15:0] OFF_STRAP_TWO = 16'h000A;
    localparam logic [15:0] OFF_STRAP_STATUS = 16'h0010;
    // first strap register fields
    localparam int BIT_CFG_DONE = 15;
    localparam int BIT_FAST_MDIX = 6;
    localparam int BIT_ROBUST_MDIX = 5;
    // second strap register fields
    localparam int BIT_FAST_LINKUP = 6;
    localparam int BIT_EXT_FD = 5;
    localparam int BIT_LED_FD_ONLY = 4;
    localparam int BIT_ISO_HD = 3;
    localparam int BIT_IDLE_ERR = 2;
    localparam int BIT_ODD_DIS = 1;
    localparam int BIT_RMII_RXCLK = 0;
    // status register fields
    localparam int BIT_STAT_BUSY = 15;
    localparam int BIT_STAT_LATCHED = 14;
    localparam logic [15:0] RESET_STRAP_ONE = 16'h0000;
    localparam logic [15:0] RESET_STRAP_TWO = 16'h0004;
    localparam logic [15:0] MASK_STRAP_ONE = 16'h0060;
    localparam logic [15:0] MASK_STRAP_TWO = 16'h3FFF;
    // internal reset pulse length
    localparam int CLK_PERIOD_NS = 40;
    localparam int STRAP_RST_NS = 200;
    localparam int STRAP_RST_CYCLES = (STRAP_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SEQ_CNT_W = 4;
    localparam logic [3:0] SEQ_CNT_LAST = 4'(STRAP_RST_CYCLES - 1);
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_PULSE,
        SEQ_LATCH
    } sst_seq_t;
endpackage

/* File: pkg/sst_cfg_if.sv */
`timescale 1ns/1ps
interface sst_cfg_if;
    logic odd_nibble_dis;
    logic core_reset;
    modport src (
        output odd_nibble_dis,
        output core_reset
    );
    modport dst (
        input odd_nibble_dis,
        input core_reset
    );
endinterface

/* File: hw/sst_latch_seq.sv */
`timescale 1ns/1ps
module sst_latch_seq (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // control
    input wire logic start,
    output logic pulse,
    output logic latch,
    output logic busy
);
    import sst_pkg::*;

    sst_seq_t state_ff;
    sst_seq_t nxt_state;
    logic [SEQ_CNT_W-1:0] cnt_ff;
    logic [SEQ_CNT_W-1:0] nxt_cnt;

    assign pulse = (state_ff == SEQ_PULSE);
    assign latch = (state_ff == SEQ_LATCH);
    assign busy = (state_ff != SEQ_IDLE);

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        case (state_ff)
            SEQ_IDLE: begin
                nxt_cnt = '0;
                if (start) nxt_state = SEQ_PULSE;
            end
            SEQ_PULSE: begin
                nxt_cnt = cnt_ff + 4'h1;
                if (cnt_ff == SEQ_CNT_LAST) nxt_state = SEQ_LATCH;
            end
            SEQ_LATCH: nxt_state = SEQ_IDLE;
            default: nxt_state = SEQ_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= SEQ_IDLE;
            cnt_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    sequence s_pulse_run;
        pulse [*5];
    endsequence
    a_pulse_then_latch: assert property (@(posedge clk) disable iff (!resetn) //R1
        (start && state_ff == SEQ_IDLE) |=> s_pulse_run ##1 latch)
        else $error("internal reset pulse length or latch wrong");
endmodule

/* File: hw/sst_odd_nibble.sv */
`timescale 1ns/1ps
module sst_odd_nibble (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // latched configuration
    sst_cfg_if.dst cfg,
    // transmit enable path, one nibble per clock
    input wire logic tx_en_in,
    input wire logic tx_er_in,
    output logic tx_en_out,
    output logic tx_er_out
);
    import sst_pkg::*;

    logic odd_ff;
    logic nxt_odd;
    logic extend;
    logic nxt_tx_en;
    logic nxt_tx_er;

    // odd_ff is high when an odd number of nibbles has gone by in the frame
    assign nxt_odd = tx_en_in & ~odd_ff;
    assign extend = ~tx_en_in & odd_ff & ~cfg.odd_nibble_dis; //R9
    assign nxt_tx_en = tx_en_in | extend; //R9
    assign nxt_tx_er = (tx_en_in & tx_er_in) | extend; //R9

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            odd_ff <= 1'b0;
            tx_en_out <= 1'b0;
            tx_er_out <= 1'b0;
        end else begin
            odd_ff <= cfg.core_reset ? 1'b0 : nxt_odd;
            tx_en_out <= nxt_tx_en;
            tx_er_out <= nxt_tx_er;
        end
    end

    a_odd_extend: assert property (@(posedge clk) disable iff (!resetn) //R9
        (!tx_en_in && odd_ff && !cfg.odd_nibble_dis && !cfg.core_reset)
        |=> (tx_en_out && tx_er_out) ##1 !tx_en_out)
        else $error("odd nibble end not extended with error");
    a_even_clean: assert property (@(posedge clk) disable iff (!resetn) //R9
        (!tx_en_in && (!odd_ff || cfg.odd_nibble_dis)) |=> !tx_en_out && !tx_er_out)
        else $error("transmit enable extended when it should not be");
endmodule

/* File: hw/sst_strap_two.sv */
`timescale 1ns/1ps
// Contract
// R1: straps loaded by software are latched after config-done and an internal reset pulse.
// R2: bits 15:14 of the second strap register ignore writes and always read zero.
// R3: the fast link-up field shortens parallel-detect link establishment when set.
// R4: fast or robust crossover mode forces the fast link-up field to one.
// R5: the extended field forces full duplex with a forced 100TX partner in auto or 100TX mode.
// R6: with the link-LED field set only a 100TX full-duplex link lights the link indicator.
// R7: with the isolation field set a half-duplex 100TX link isolates the MII outputs.
// R8: the idle symbol-error field, one after reset, enables idle receive symbol errors.
// R9: unless disabled, TX_EN falling after an odd nibble is stretched one cycle as an error.
// R10: RMII receive data follow RX_CLK when the clock field is one, else the reference clock.
// R11: the register is 16 bits wide and a strap change acts only after the latch sequence.
module sst_strap_two (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RESETN,
    // register port
    input wire logic [sst_pkg::ADDR_W-1:0] ADDR,
    input wire logic [sst_pkg::DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [sst_pkg::DATA_W-1:0] RDATA,
    // link state from the transceiver core, same clock
    input wire logic LINK_UP,
    input wire logic SPEED_100,
    input wire logic AUTONEG_ENABLE,
    input wire logic LOCAL_FORCED_100TX,
    input wire logic PARTNER_FORCED_100TX,
    input wire logic PARALLEL_DETECT,
    input wire logic RESOLVED_FULL_DUPLEX,
    input wire logic LINE_IDLE,
    input wire logic RX_SYMBOL_ERROR,
    // MAC transmit pins
    input wire logic TX_EN,
    input wire logic TX_ER,
    // effects
    output logic CORE_RESET,
    output logic FAST_PD_LINKUP,
    output logic LINK_FULL_DUPLEX,
    output logic LINK_LED,
    output logic MII_ISOLATE,
    output logic RX_IDLE_ERROR,
    output logic RMII_RX_CLK_SEL,
    output logic TX_EN_CORE,
    output logic TX_ER_CORE
);
    import sst_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // register decode

    logic [15:0] strap_one_ff;
    logic [15:0] strap_two_ff;
    logic [15:0] active_two_ff;
    logic [15:0] rdata_ff;
    logic [15:0] nxt_rdata;
    logic latched_ff;
    logic mdix_auto_fast;
    logic [15:0] strap_two_view;
    logic [15:0] status_view;
    logic hit_one;
    logic hit_two;
    logic hit_status;
    logic wr_one;
    logic wr_two;
    logic cfg_start;
    logic seq_pulse;
    logic seq_latch;
    logic seq_busy;

    // exact word compare: no register answers at an aliased address
    function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        return (a == off);
    endfunction

    assign hit_one = addr_hit(ADDR, OFF_STRAP_ONE);
    assign hit_two = addr_hit(ADDR, OFF_STRAP_TWO);
    assign hit_status = addr_hit(ADDR, OFF_STRAP_STATUS);
    assign wr_one = WR & hit_one;
    assign wr_two = WR & hit_two;
    // a second config-done while a sequence runs is dropped, the running one latches
    assign cfg_start = wr_one & WDATA[BIT_CFG_DONE] & ~seq_busy; //R1

    // crossover modes pin the fast link-up bit high, both in the view and when latched
    assign mdix_auto_fast = strap_one_ff[BIT_FAST_MDIX] | strap_one_ff[BIT_ROBUST_MDIX];
    assign strap_two_view = (strap_two_ff & MASK_STRAP_TWO) //R2
        | (16'(mdix_auto_fast) << BIT_FAST_LINKUP); //R4

    assign status_view = {seq_busy, latched_ff, active_two_ff[13:0]};

    // read data fall back to zero outside the read slot, so a late sample sees nothing stale
    assign nxt_rdata = !RD ? 16'h0000 :
        hit_one ? {latched_ff, strap_one_ff[14:0] & MASK_STRAP_ONE[14:0]} :
        hit_two ? strap_two_view :
        hit_status ? status_view : 16'h0000;

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            strap_one_ff <= RESET_STRAP_ONE;
            strap_two_ff <= RESET_STRAP_TWO; //R8
            rdata_ff <= 16'h0000;
        end else begin
            if (wr_one) strap_one_ff <= WDATA & MASK_STRAP_ONE;
            if (wr_two) strap_two_ff <= WDATA & MASK_STRAP_TWO; //R2
            rdata_ff <= nxt_rdata;
        end
    end

    assign RDATA = rdata_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // config-done sequence: internal reset pulse then latch

    sst_latch_seq u_seq (
        .clk(CLOCK),
        .resetn(RESETN),
        .start(cfg_start),
        .pulse(seq_pulse),
        .latch(seq_latch),
        .busy(seq_busy)
    );

    // straps steer nothing until latched, so a half-written set never leaks out
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            active_two_ff <= RESET_STRAP_TWO;
            latched_ff <= 1'b0;
        end else if (seq_latch) begin
            active_two_ff <= strap_two_view; //R11
            latched_ff <= 1'b1; //R1
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers for the MAC transmit inputs

    // only the second stage is read; the first may still be settling
    logic [1:0] tx_en_sync_ff;
    logic [1:0] tx_er_sync_ff;

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            tx_en_sync_ff <= 2'b00;
            tx_er_sync_ff <= 2'b00;
        end else begin
            tx_en_sync_ff <= {tx_en_sync_ff[0], TX_EN};
            tx_er_sync_ff <= {tx_er_sync_ff[0], TX_ER};
        end
    end

    sst_cfg_if u_cfg ();
    assign u_cfg.odd_nibble_dis = active_two_ff[BIT_ODD_DIS]; //R9
    assign u_cfg.core_reset = seq_pulse;

    sst_odd_nibble u_odd (
        .clk(CLOCK),
        .resetn(RESETN),
        .cfg(u_cfg.dst),
        .tx_en_in(tx_en_sync_ff[1]),
        .tx_er_in(tx_er_sync_ff[1]),
        .tx_en_out(TX_EN_CORE),
        .tx_er_out(TX_ER_CORE)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // effects of the latched straps

    logic ext_fd_case;
    logic full_duplex;
    logic hd_100;
    logic nxt_fast_pd;
    logic nxt_fd;
    logic nxt_led;
    logic nxt_iso;
    logic nxt_idle_err;
    logic nxt_rmii_sel;
    logic fast_pd_ff;
    logic fd_ff;
    logic led_ff;
    logic iso_ff;
    logic idle_err_ff;
    logic rmii_sel_ff;
    logic core_reset_ff;

    // an autonegotiating partner resolves duplex itself, so only a forced one qualifies
    assign ext_fd_case = (AUTONEG_ENABLE | LOCAL_FORCED_100TX) & PARTNER_FORCED_100TX;
    assign full_duplex = (active_two_ff[BIT_EXT_FD] & ext_fd_case) //R5
        | RESOLVED_FULL_DUPLEX;
    assign hd_100 = LINK_UP & SPEED_100 & ~full_duplex;

    assign nxt_fast_pd = active_two_ff[BIT_FAST_LINKUP] & PARALLEL_DETECT; //R3
    assign nxt_fd = LINK_UP & full_duplex; //R5
    assign nxt_led = active_two_ff[BIT_LED_FD_ONLY] ? //R6
        (LINK_UP & SPEED_100 & full_duplex) : LINK_UP;
    assign nxt_iso = active_two_ff[BIT_ISO_HD] & hd_100; //R7
    assign nxt_idle_err = active_two_ff[BIT_IDLE_ERR] & LINE_IDLE & RX_SYMBOL_ERROR; //R8
    // the clock select is not quieted: the receive path keeps a defined reference in the pulse
    assign nxt_rmii_sel = active_two_ff[BIT_RMII_RXCLK]; //R10

    // during the internal reset pulse the link side is held quiet
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            fast_pd_ff <= 1'b0;
            fd_ff <= 1'b0;
            led_ff <= 1'b0;
            iso_ff <= 1'b0;
            idle_err_ff <= 1'b0;
            rmii_sel_ff <= 1'b0;
            core_reset_ff <= 1'b0;
        end else begin
            fast_pd_ff <= nxt_fast_pd & ~seq_pulse;
            fd_ff <= nxt_fd & ~seq_pulse;
            led_ff <= nxt_led & ~seq_pulse;
            iso_ff <= nxt_iso & ~seq_pulse;
            idle_err_ff <= nxt_idle_err & ~seq_pulse;
            rmii_sel_ff <= nxt_rmii_sel;
            core_reset_ff <= seq_pulse; //R1
        end
    end

    assign FAST_PD_LINKUP = fast_pd_ff;
    assign LINK_FULL_DUPLEX = fd_ff;
    assign LINK_LED = led_ff;
    assign MII_ISOLATE = iso_ff;
    assign RX_IDLE_ERROR = idle_err_ff;
    assign RMII_RX_CLK_SEL = rmii_sel_ff;
    assign CORE_RESET = core_reset_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RESETN);

    sequence s_core_pulse;
        CORE_RESET [*5];
    endsequence
    sequence s_latch_shown;
        !CORE_RESET && latched_ff && !seq_busy;
    endsequence
    sequence s_effects_quiet;
        !FAST_PD_LINKUP && !LINK_FULL_DUPLEX && !LINK_LED && !MII_ISOLATE && !RX_IDLE_ERROR;
    endsequence

    // register port
    a_reserved_zero: assert property ($past(RD) && $past(hit_two) |-> RDATA[15:14] == 2'b00) //R2
        else $error("reserved strap bits read nonzero");
    a_reserved_write: assert property (wr_two |=> strap_two_ff[15:14] == 2'b00) //R2
        else $error("reserved strap bits stored");
    a_read_slot: assert property (!$past(RD) |-> RDATA == 16'h0000)
        else $error("read data outside the read slot");
    a_mdix_forces: assert property ((RD && hit_two && mdix_auto_fast) |=> RDATA[6]) //R4
        else $error("crossover mode did not force fast link-up");
    a_status_flags: assert property ((RD && hit_status) //R1
        |=> RDATA[15:14] == $past({seq_busy, latched_ff}))
        else $error("status flags read wrong");

    // config-done sequence: five pulse cycles, then the latched copy shows
    a_done_resets: assert property (cfg_start |=> ##1 s_core_pulse ##1 s_latch_shown) //R1
        else $error("config done did not pulse and latch");
    a_quiet_pulse: assert property (seq_pulse |=> s_effects_quiet) //R1
        else $error("link effects active during internal reset");
    a_write_deferred: assert property ((wr_two && !seq_latch) |=> $stable(active_two_ff)) //R11
        else $error("strap write acted before the latch");
    a_latch_forces: assert property ((seq_latch && mdix_auto_fast) //R4
        |=> active_two_ff[BIT_FAST_LINKUP])
        else $error("crossover mode did not force the latched fast link-up");

    // effects lag the core levels by one register
    a_fast_pd: assert property ((!active_two_ff[6]) |=> !FAST_PD_LINKUP) //R3
        else $error("fast parallel-detect link-up while disabled");
    a_fast_pd_on: assert property ((active_two_ff[6] && PARALLEL_DETECT && !seq_pulse) //R3
        |=> FAST_PD_LINKUP)
        else $error("fast parallel-detect link-up missing");
    a_ext_fd: assert property ((active_two_ff[5] && LINK_UP && ext_fd_case && !seq_pulse) //R5
        |=> LINK_FULL_DUPLEX)
        else $error("extended full duplex not applied");
    a_std_fd: assert property ((!active_two_ff[5] && !seq_pulse) //R5
        |=> LINK_FULL_DUPLEX == $past(LINK_UP && RESOLVED_FULL_DUPLEX))
        else $error("duplex differs from the standard resolution");
    a_led_fd_only: assert property ((active_two_ff[4] && !SPEED_100 && !seq_pulse) //R6
        |=> !LINK_LED)
        else $error("link LED lit without 100TX full duplex");
    a_led_any_link: assert property ((!active_two_ff[4] && !seq_pulse) //R6
        |=> LINK_LED == $past(LINK_UP))
        else $error("link LED does not follow the link");
    a_no_link_dark: assert property (!LINK_UP |=> !LINK_FULL_DUPLEX && !LINK_LED) //R6
        else $error("link effects without a link");
    a_iso_hd: assert property ((active_two_ff[3] && hd_100 && !seq_pulse) |=> MII_ISOLATE) //R7
        else $error("MII outputs not isolated on 100TX half duplex");
    a_iso_off: assert property (!active_two_ff[3] |=> !MII_ISOLATE) //R7
        else $error("MII outputs isolated while disabled");
    a_iso_needs_hd: assert property (!hd_100 |=> !MII_ISOLATE) //R7
        else $error("MII outputs isolated without a 100TX half-duplex link");
    a_idle_err_off: assert property (!active_two_ff[2] |=> !RX_IDLE_ERROR) //R8
        else $error("idle symbol error reported while disabled");
    a_idle_err_on: assert property ((active_two_ff[2] && LINE_IDLE && RX_SYMBOL_ERROR //R8
        && !seq_pulse) |=> RX_IDLE_ERROR)
        else $error("idle symbol error not reported");
    a_rmii_sel: assert property (RMII_RX_CLK_SEL == $past(active_two_ff[0])) //R10
        else $error("receive clock select does not follow latched strap");
endmodule

/* File: verification/sst_strap_two_bench.sv */
`timescale 1ns/1ps
module sst_strap_two_bench;
    import sst_pkg::*;

    logic clock, resetn, wr, rd, tx_en, tx_er, core_reset, en_o, er_o;
    logic [15:0] addr, wdata, rdata, act, nv, sv;
    logic [8:0] st;
    logic [5:0] eff;
    logic [1:0] xo;
    logic [31:0] seed;
    int n_mismatch, num_checks, cyc, en_cnt, er_cnt, pulse;

    sst_strap_two u_sst_strap_two (
        .CLOCK(clock), .RESETN(resetn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .LINK_UP(st[0]), .SPEED_100(st[1]), .AUTONEG_ENABLE(st[2]),
        .LOCAL_FORCED_100TX(st[3]), .PARTNER_FORCED_100TX(st[4]), .PARALLEL_DETECT(st[5]),
        .RESOLVED_FULL_DUPLEX(st[6]), .LINE_IDLE(st[7]), .RX_SYMBOL_ERROR(st[8]),
        .TX_EN(tx_en), .TX_ER(tx_er), .CORE_RESET(core_reset), .FAST_PD_LINKUP(eff[5]),
        .LINK_FULL_DUPLEX(eff[4]), .LINK_LED(eff[3]), .MII_ISOLATE(eff[2]),
        .RX_IDLE_ERROR(eff[1]), .RMII_RX_CLK_SEL(eff[0]), .TX_EN_CORE(en_o),
        .TX_ER_CORE(er_o)
    );

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // effect outputs expected from the latched copy and the core levels
    function automatic logic [5:0] exp_eff(input logic [15:0] a, input logic [8:0] s);
        logic fd;
        fd = s[0] & (s[6] | a[BIT_EXT_FD] & (s[2] | s[3]) & s[4]);
        return {a[BIT_FAST_LINKUP] & s[5], fd, a[BIT_LED_FD_ONLY] ? s[0] & s[1] & fd : s[0],
                a[BIT_ISO_HD] & s[0] & s[1] & !fd, a[BIT_IDLE_ERR] & s[7] & s[8],
                a[BIT_RMII_RXCLK]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clock);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp, input string what);
        @(posedge clock);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        #1 check(what, exp, rdata);
    endtask

    task automatic effects(input int n);
        repeat (n) begin
            seed = lfsr(seed);
            @(posedge clock);
            st <= seed[8:0];
            @(posedge clock);
            #1 check("effects", {10'h000, exp_eff(act, st)}, {10'h000, eff});
        end
    endtask

    // frame of n nibbles with TX_ER at er; the pipeline is short, so 8 idle cycles drain it
    task automatic frame(input int n, input logic er);
        logic odd;
        odd = n[0] & !act[BIT_ODD_DIS];
        @(posedge clock);
        #1 en_cnt = 0;
        er_cnt = 0;
        repeat (n) @(posedge clock) {tx_en, tx_er} <= {1'b1, er};
        @(posedge clock) {tx_en, tx_er} <= 2'b00;
        repeat (8) @(posedge clock);
        #1 check("tx_en length", 16'(n + int'(odd)), 16'(en_cnt));
        check("tx_er length", 16'(er ? n + int'(odd) : int'(odd)), 16'(er_cnt));
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    always @(posedge clock) begin
        en_cnt += int'(en_o);
        er_cnt += int'(er_o);
        pulse += int'(core_reset);
        cyc++;
        if (cyc > 20000) begin
            n_mismatch++;
            end_sim();
        end
    end

    initial begin
        {wr, rd, tx_en, tx_er} = 4'h0;
        addr = 16'h0000;
        wdata = 16'h0000;
        st = 9'h000;
        seed = 32'h0001_208e;
        act = RESET_STRAP_TWO;
        resetn = 1'b0;
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        rd_chk(OFF_STRAP_TWO, 16'h0004, "strap two reset");
        rd_chk(OFF_STRAP_STATUS, 16'h0004, "status reset");
        rd_chk(OFF_STRAP_ONE, 16'h0000, "strap one reset");
        rd_chk(16'h000B, 16'h0000, "unmapped read");
        effects(8);
        $display("test reset done");
        for (int r = 0; r < 6; r++) begin
            seed = lfsr(seed);
            sv = (r == 0) ? 16'h0000 : (r == 1) ? 16'hFFFF : seed[15:0];
            xo = (r == 0) ? 2'b01 : (r == 1) ? 2'b00 : (r == 2) ? 2'b10 : seed[17:16];
            nv = (sv & MASK_STRAP_TWO) | ((xo != 2'b00) ? 16'h0040 : 16'h0000);
            reg_wr(OFF_STRAP_ONE, {9'h000, xo, 5'h00});
            reg_wr(OFF_STRAP_TWO, sv);
            reg_wr(16'h000B, 16'hFFFF);
            rd_chk(OFF_STRAP_TWO, nv, "strap two readback");
            // new straps must not act before the latch sequence
            effects(4);
            pulse = 0;
            reg_wr(OFF_STRAP_ONE, {1'b1, 8'h00, xo, 5'h00});
            // a config-done write while the pulse runs must not restart it
            if (r[0]) reg_wr(OFF_STRAP_ONE, {1'b1, 8'h00, xo, 5'h00});
            repeat (12) @(posedge clock);
            #1 check("reset pulse length", 16'(STRAP_RST_CYCLES), 16'(pulse));
            act = nv;
            rd_chk(OFF_STRAP_STATUS, 16'h4000 | act, "latched copy");
            rd_chk(OFF_STRAP_ONE, {1'b1, 8'h00, xo, 5'h00}, "config done");
            effects(20);
            frame(3, 1'b0);
            frame(4, 1'b1);
            frame(1, seed[20]);
            $display("test round %0d done", r);
        end
        end_sim();
    end
endmodule
